/* rtl/csf_pkg.sv */
// Constants for the clock source status and interrupt flag block
package csf_pkg;

    // Number of event/status positions handled by the block
    localparam int unsigned FLAG_W = 12;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_INT_ENABLE_CLEAR = 8'h00;
    localparam logic [7:0] OFS_INT_ENABLE_SET   = 8'h04;
    localparam logic [7:0] OFS_INT_FLAG         = 8'h08;
    localparam logic [7:0] OFS_POWER_CLOCK_STAT = 8'h0c;

    // Values after reset
    localparam logic [31:0] RST_POWER_CLOCK_STAT = 32'h0000_0000;
    localparam logic [31:0] RST_INT_FLAG         = 32'h0000_0000;
    localparam logic [31:0] RST_INT_ENABLE       = 32'h0000_0000;

    // Bit positions shared by status, flag and enable registers
    localparam int unsigned BIT_CRYSTAL_MAIN_READY  = 0;
    localparam int unsigned BIT_CRYSTAL_32KHZ_READY = 1;
    localparam int unsigned BIT_RC_32KHZ_READY      = 2;
    localparam int unsigned BIT_RC_8MHZ_READY       = 3;
    localparam int unsigned BIT_FLL_SYNC_READY      = 4;
    localparam int unsigned BIT_FLL_OUT_OF_BOUNDS   = 5;
    localparam int unsigned BIT_FLL_FINE_LOCK       = 6;
    localparam int unsigned BIT_FLL_COARSE_LOCK     = 7;
    localparam int unsigned BIT_FLL_REF_CLK_STOPPED = 8;
    localparam int unsigned BIT_BROWNOUT_READY      = 9;
    localparam int unsigned BIT_BROWNOUT_DETECTED   = 10;
    localparam int unsigned BIT_BROWNOUT_SYNC_BUSY  = 11;

    // Bits per byte lane, used to find the lane that carries each flag bit
    localparam int unsigned LANE_W = 8;

    // Cycles from a taken request to ack
    localparam int unsigned ACK_LATENCY = 1;

endpackage : csf_pkg

/* rtl/csf_edge_flag.sv */
// One sticky flag set by a rising edge of a sampled status level
`timescale 1ns/1ns
module csf_edge_flag (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic level_i,
    input  wire logic clear_i,
    output logic      level_o,
    output logic      flag_o
);

    typedef struct packed {
        logic level_reg;
        logic flag_reg;
    } csf_edge_state_t;

    csf_edge_state_t st_reg;
    csf_edge_state_t st_next;

    always_comb begin
        st_next           = st_reg;
        st_next.level_reg = level_i;
        // Set beats clear so an edge in the clearing cycle is kept
        if (level_i && !st_reg.level_reg) begin
            st_next.flag_reg = 1'b1;
        end else if (clear_i) begin
            st_next.flag_reg = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.level_reg;
    assign flag_o  = st_reg.flag_reg;

endmodule : csf_edge_flag

/* rtl/csf_status_flags.sv */
// Clock source status register, sticky ready flags and interrupt request
// Summary of operation
// - FLL ready rising edge sets flag, irq
// - 8 MHz RC ready edge sets flag
// - 32 kHz RC ready edge sets flag
// - 32 kHz crystal ready edge sets flag
// - Main crystal ready edge sets flag
// - Write one clears flag, zero ignored
// - Status register read-only, resets zero
// - Bit 11 shows brownout sync busy
// - Bit 10 shows brownout detection
// - Bit 9 shows brownout monitor ready
// - Bit 8 shows FLL reference stopped
// - Bit 7 shows FLL coarse lock
// - Bit 6 shows FLL fine lock
// - Bit 5 shows FLL out of bounds
// - Bit 4 shows FLL register sync state
// - Bits 3..0 show oscillator ready levels
// - Enable set writes ones only
// - Flag register at 0x08, upper zero
`timescale 1ns/1ns
module csf_status_flags #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Classic Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Status levels from the oscillators, the loop and the brownout monitor
    input  wire logic              crystal_main_ready_i,
    input  wire logic              crystal_32khz_ready_i,
    input  wire logic              rc_32khz_ready_i,
    input  wire logic              rc_8mhz_ready_i,
    input  wire logic              fll_sync_ready_i,
    input  wire logic              fll_out_of_bounds_i,
    input  wire logic              fll_fine_lock_i,
    input  wire logic              fll_coarse_lock_i,
    input  wire logic              fll_ref_clock_stopped_i,
    input  wire logic              brownout_ready_i,
    input  wire logic              brownout_detected_i,
    input  wire logic              brownout_sync_busy_i,
    // Interrupt request
    output logic                   irq_o
);

    localparam int unsigned FW = csf_pkg::FLAG_W;

    typedef struct packed {
        logic          ack_reg;
        logic [31:0]   dat_reg;
        logic [FW-1:0] enable_reg;
        logic          irq_reg;
    } csf_state_t;

    csf_state_t st_reg;
    csf_state_t st_next;

    logic [FW-1:0] status_in;
    logic [FW-1:0] status_level;
    logic [FW-1:0] flag_level;
    logic [FW-1:0] flag_clear;
    logic [FW-1:0] wr_mask;
    logic [FW-1:0] wr_ones;
    logic [7:0]    reg_ofs;
    logic          req_new;
    logic          wr_new;

    // Gather the status levels in register bit order
    always_comb begin
        status_in = '0;
        status_in[csf_pkg::BIT_CRYSTAL_MAIN_READY]  = crystal_main_ready_i;
        status_in[csf_pkg::BIT_CRYSTAL_32KHZ_READY] = crystal_32khz_ready_i;
        status_in[csf_pkg::BIT_RC_32KHZ_READY]      = rc_32khz_ready_i;
        status_in[csf_pkg::BIT_RC_8MHZ_READY]       = rc_8mhz_ready_i;
        // loop sync level passed through unchanged
        status_in[csf_pkg::BIT_FLL_SYNC_READY]      = fll_sync_ready_i;
        status_in[csf_pkg::BIT_FLL_OUT_OF_BOUNDS]   = fll_out_of_bounds_i;
        status_in[csf_pkg::BIT_FLL_FINE_LOCK]       = fll_fine_lock_i;
        status_in[csf_pkg::BIT_FLL_COARSE_LOCK]     = fll_coarse_lock_i;
        status_in[csf_pkg::BIT_FLL_REF_CLK_STOPPED] = fll_ref_clock_stopped_i;
        status_in[csf_pkg::BIT_BROWNOUT_READY]      = brownout_ready_i;
        status_in[csf_pkg::BIT_BROWNOUT_DETECTED]   = brownout_detected_i;
        status_in[csf_pkg::BIT_BROWNOUT_SYNC_BUSY]  = brownout_sync_busy_i;
    end

    // Bus decode; a request is taken once, in the cycle before ack
    assign req_new = wb_cyc_i && wb_stb_i && !st_reg.ack_reg;
    assign wr_new  = req_new && wb_we_i;
    assign reg_ofs = 8'(wb_adr_i);

    // Byte enables gate each flag and enable bit by its lane
    always_comb begin
        wr_mask = '0;
        for (int i = 0; i < FW; i++) begin
            wr_mask[i] = wb_sel_i[i / csf_pkg::LANE_W];
        end
        wr_ones = wb_dat_i[FW-1:0] & wr_mask;
    end

    assign flag_clear = (wr_new && reg_ofs == csf_pkg::OFS_INT_FLAG) ? wr_ones : '0;

    // edge flags sampled in this clock
    genvar g;
    generate
        for (g = 0; g < FW; g++) begin : g_flag
            csf_edge_flag u_flag (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .level_i (status_in[g]),
                .clear_i (flag_clear[g]),
                .level_o (status_level[g]),
                .flag_o  (flag_level[g])
            );
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        // Ack for one cycle per request, then drop
        st_next.ack_reg = req_new;
        if (req_new) begin
            st_next.dat_reg = '0;
            if (!wb_we_i) begin
                case (reg_ofs)
                    csf_pkg::OFS_INT_ENABLE_CLEAR,
                    csf_pkg::OFS_INT_ENABLE_SET: begin
                        st_next.dat_reg[FW-1:0] = st_reg.enable_reg;
                    end
                    csf_pkg::OFS_INT_FLAG: begin
                        st_next.dat_reg[FW-1:0] = flag_level;
                    end
                    csf_pkg::OFS_POWER_CLOCK_STAT: begin
                        st_next.dat_reg[FW-1:0] = status_level;
                    end
                    default: begin
                        st_next.dat_reg = '0;
                    end
                endcase
            end
        end
        if (wr_new) begin
            case (reg_ofs)
                csf_pkg::OFS_INT_ENABLE_CLEAR: begin
                    st_next.enable_reg = st_reg.enable_reg & ~wr_ones;
                end
                csf_pkg::OFS_INT_ENABLE_SET: begin
                    st_next.enable_reg = st_reg.enable_reg | wr_ones;
                end
                // Status writes and unmapped writes are dropped
                default: begin
                    st_next.enable_reg = st_reg.enable_reg;
                end
            endcase
        end
        st_next.irq_reg = |(flag_level & st_reg.enable_reg);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg            <= '0;
            st_reg.enable_reg <= csf_pkg::RST_INT_ENABLE[FW-1:0];
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack_o = st_reg.ack_reg;
    assign wb_dat_o = st_reg.dat_reg;
    assign irq_o    = st_reg.irq_reg;

endmodule : csf_status_flags

/* sim/csf_status_flags_monitor.sv */
// Port assertions for the clock source status block
`timescale 1ns/1ns
module csf_status_flags_monitor #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i, wb_dat_o,
    input wire logic              crystal_main_ready_i, crystal_32khz_ready_i, rc_32khz_ready_i, rc_8mhz_ready_i,
    input wire logic              fll_sync_ready_i, fll_out_of_bounds_i, fll_fine_lock_i, fll_coarse_lock_i,
    input wire logic              fll_ref_clock_stopped_i, brownout_ready_i, brownout_detected_i,
    input wire logic              brownout_sync_busy_i
);
    logic [11:0] st;
    logic        req;
    assign st = {brownout_sync_busy_i, brownout_detected_i, brownout_ready_i, fll_ref_clock_stopped_i,
                 fll_coarse_lock_i, fll_fine_lock_i, fll_out_of_bounds_i, fll_sync_ready_i,
                 rc_8mhz_ready_i, rc_32khz_ready_i, crystal_32khz_ready_i, crystal_main_ready_i};
    // Held strobes in the ack cycle are not a new request
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_after_req_a: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    // Stable levels keep both sampling readings equal
    status_read_a: assert property (req && !wb_we_i && wb_adr_i == 8'h0c && $stable(st)
        |=> wb_dat_o == {20'h0, $past(st)})
        else $error("status read mismatch");
    flag_upper_zero_a: assert property (req && !wb_we_i && wb_adr_i == 8'h08
        |=> wb_dat_o[31:12] == 20'h0)
        else $error("flag upper bits not zero");
    unmapped_zero_a: assert property (req && !wb_we_i && wb_adr_i[7:4] != 4'h0 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    dat_hold_a: assert property (!req |=> $stable(wb_dat_o))
        else $error("read data changed without request");
    irq_clear_a: assert property (req && wb_we_i && wb_sel_i[1:0] == 2'b11 && wb_dat_i[11:0] == 12'hfff
        && (wb_adr_i == 8'h00 || wb_adr_i == 8'h08) && $stable(st) |-> ##2 !irq_o)
        else $error("irq stayed after clear");
endmodule : csf_status_flags_monitor

bind csf_status_flags csf_status_flags_monitor #(.ADDR_W(ADDR_W)) mon (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_ack_o                (wb_ack_o),
    .irq_o                   (irq_o),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .crystal_main_ready_i    (crystal_main_ready_i),
    .crystal_32khz_ready_i   (crystal_32khz_ready_i),
    .rc_32khz_ready_i        (rc_32khz_ready_i),
    .rc_8mhz_ready_i         (rc_8mhz_ready_i),
    .fll_sync_ready_i        (fll_sync_ready_i),
    .fll_out_of_bounds_i     (fll_out_of_bounds_i),
    .fll_fine_lock_i         (fll_fine_lock_i),
    .fll_coarse_lock_i       (fll_coarse_lock_i),
    .fll_ref_clock_stopped_i (fll_ref_clock_stopped_i),
    .brownout_ready_i        (brownout_ready_i),
    .brownout_detected_i     (brownout_detected_i),
    .brownout_sync_busy_i    (brownout_sync_busy_i)
);

/* sim/tb_csf_status_flags.sv */
// Self-checking bench for the clock source status block
`timescale 1ns/1ns
module tb_csf_status_flags;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  lanes = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [11:0] st = 12'h000;
    int          failures = 0, num_checks = 0;
    always #4 clk_i = ~clk_i;
    csf_status_flags uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
        .crystal_main_ready_i(st[0]), .crystal_32khz_ready_i(st[1]), .rc_32khz_ready_i(st[2]),
        .rc_8mhz_ready_i(st[3]), .fll_sync_ready_i(st[4]), .fll_out_of_bounds_i(st[5]), .fll_fine_lock_i(st[6]),
        .fll_coarse_lock_i(st[7]), .fll_ref_clock_stopped_i(st[8]), .brownout_ready_i(st[9]),
        .brownout_detected_i(st[10]), .brownout_sync_busy_i(st[11]));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    // The wait has no bound of its own; the watchdog ends a hang
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= lanes;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rdat, e);
    endtask : rd
    initial begin
        #20000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h0c, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h20, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            st <= 12'h001 << i;
            repeat (3) @(posedge clk_i);
            rd(8'h0c, 32'h1 << i);
        end
        st <= 12'h000;
        rd(8'h08, 32'hfff);
        bus(1'b1, 8'h08, 32'h0);
        rd(8'h08, 32'hfff);
        bus(1'b1, 8'h08, 32'h00f);
        rd(8'h08, 32'hff0);
        // Only lane 1 enabled, so bits 7:0 must survive the clear
        lanes <= 4'h2;
        bus(1'b1, 8'h08, 32'hfff);
        lanes <= 4'hf;
        rd(8'h08, 32'h0f0);
        bus(1'b1, 8'h0c, 32'hffffffff);
        rd(8'h0c, 32'h0);
        rd(8'h08, 32'h0f0);
        $display("flag test done");
        bus(1'b1, 8'h04, 32'h010);
        bus(1'b1, 8'h04, 32'h0);
        rd(8'h04, 32'h010);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h08, 32'hfff);
        rd(8'h08, 32'h0);
        check({31'h0, irq}, 32'h0);
        @(posedge clk_i);
        st <= 12'h010;
        repeat (3) @(posedge clk_i);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h00, 32'hfff);
        // Irq is registered one edge after the enable drops
        @(posedge clk_i);
        check({31'h0, irq}, 32'h0);
        rd(8'h08, 32'h010);
        rd(8'h04, 32'h0);
        $display("enable test done");
        end_of_test();
    end
endmodule : tb_csf_status_flags
